/* hdl/t1pli_port_line.sv */
`timescale 1ns/1ps
`default_nettype none

module t1pli_port_line (
    // system clock and reset
    input  wire  logic        clk_sys,
    input  wire  logic        rst,
    // apb slave
    input  wire  logic        psel,
    input  wire  logic        penable,
    input  wire  logic        pwrite,
    input  wire  logic [31:0] paddr,
    input  wire  logic [31:0] pwdata,
    output var   logic [31:0] prdata,
    output var   logic        pready,
    output var   logic        pslverr,
    // receive data from the mapper core, pos doubles as nrz
    input  wire  logic [3:0]  rx_pos_data,
    input  wire  logic [3:0]  rx_neg_data,
    // receive line pins
    output var   logic [3:0]  rx_line_clock_out,
    output var   logic [3:0]  rx_line_clock_oe,
    output var   logic [3:0]  rx_pos_or_nrz_out,
    output var   logic [3:0]  rx_pos_or_nrz_oe,
    output var   logic [3:0]  rx_neg_rail_out,
    output var   logic [3:0]  rx_neg_rail_oe,
    input  wire  logic [3:0]  rx_squelch_in,
    // transmit line pins, one shared line clock
    input  wire  logic        tx_line_clock_in,
    input  wire  logic [3:0]  tx_pos_or_nrz_in,
    input  wire  logic [3:0]  tx_neg_rail_or_los_in,
    // transmit samples handed to the mapper core
    output var   logic [3:0]  tx_pos_sample,
    output var   logic [3:0]  tx_neg_sample,
    output var   logic [3:0]  tx_los_active,
    output var   logic        tx_sample_strobe,
    // global pins
    input  wire  logic        global_tristate_select,
    input  wire  logic        desync_reference_clock
);

    // ------------------------------------------------------------------
    // state records
    // ------------------------------------------------------------------
    typedef struct packed {
        t1pli_pkg::t1pli_bus_state_t bus;
        logic        rx_inv;
        logic        tx_inv;
        logic [3:0]  bypass;
        logic [3:0]  rx_en;
        logic [3:0]  sq_m;
        logic [3:0]  sq;
        logic        hz_m;
        logic        hz_n;
        logic        tog_m;
        logic        tog_s;
        logic        tog_d;
        logic [3:0]  tx_pos;
        logic [3:0]  tx_neg;
        logic [3:0]  los;
        logic        tx_stb;
        logic [5:0]  div_cnt;
        logic        line_clk;
        logic [3:0]  rx_pos_q;
        logic [3:0]  rx_neg_q;
        logic [3:0]  clk_out;
        logic [3:0]  clk_oe;
        logic [3:0]  pos_out;
        logic [3:0]  pos_oe;
        logic [3:0]  neg_out;
        logic [3:0]  neg_oe;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } t1pli_sys_t;

    typedef struct packed {
        logic       rst_m;
        logic       rst_s;
        logic       inv_m;
        logic       inv_s;
        logic [3:0] word_pos;
        logic [3:0] word_neg;
        logic       tog;
    } t1pli_link_t;

    typedef struct packed {
        logic [3:0] pos;
        logic [3:0] neg;
    } t1pli_fall_t;

    t1pli_sys_t  st;
    t1pli_sys_t  next_st;
    t1pli_link_t lk;
    t1pli_link_t next_lk;
    t1pli_fall_t fc;

    // reference clock feeds the desynchroniser, which lives outside this block
    logic unused_ref;
    assign unused_ref = desync_reference_clock;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [3:0] t1pli_drive(input logic [3:0] want, input logic hz_n);
        t1pli_drive = want & {4{hz_n}};
    endfunction

    // ------------------------------------------------------------------
    // link domain: transmit sampling
    // ------------------------------------------------------------------
    // falling edge capture; only used when the invert bit is clear
    always_ff @(negedge tx_line_clock_in) begin
        fc.pos <= tx_pos_or_nrz_in;
        fc.neg <= tx_neg_rail_or_los_in;
    end

    always_comb begin
        next_lk = lk;
        next_lk.rst_m = rst;
        next_lk.rst_s = lk.rst_m;
        next_lk.inv_m = st.tx_inv;
        next_lk.inv_s = lk.inv_m;
        if (lk.inv_s) begin
            next_lk.word_pos = tx_pos_or_nrz_in;
            next_lk.word_neg = tx_neg_rail_or_los_in;
        end else begin
            next_lk.word_pos = fc.pos;
            next_lk.word_neg = fc.neg;
        end
        next_lk.tog = ~lk.tog;
        if (lk.rst_s) begin
            next_lk.word_pos = 4'h0;
            next_lk.word_neg = 4'hF;
            next_lk.tog      = 1'b0;
        end
    end

    always_ff @(posedge tx_line_clock_in) begin
        lk <= next_lk;
    end

    // ------------------------------------------------------------------
    // system domain
    // ------------------------------------------------------------------
    logic       acc;
    logic       wr_ok;
    logic       addr_ctrl;
    logic       addr_stat;
    logic       tick;
    logic       launch;

    assign acc       = psel && penable;
    assign addr_ctrl = (paddr[11:0] == t1pli_pkg::CTRL_ADDR) && (paddr[31:12] == 20'h00000);
    assign addr_stat = (paddr[11:0] == t1pli_pkg::STATUS_ADDR) && (paddr[31:12] == 20'h00000);
    assign wr_ok     = acc && st.pready && pwrite && addr_ctrl;
    assign tick      = (st.div_cnt == t1pli_pkg::RX_HALF_LAST);
    // launch on the rising line edge, or on the falling one when inverted
    assign launch    = tick && (st.line_clk == st.rx_inv);

    always_comb begin
        next_st = st;
        // pin synchronisers
        next_st.sq_m  = rx_squelch_in;
        next_st.sq    = st.sq_m;
        next_st.hz_m  = global_tristate_select;
        next_st.hz_n  = st.hz_m;
        next_st.tog_m = lk.tog;
        next_st.tog_s = st.tog_m;
        next_st.tog_d = st.tog_s;

        // transmit word crossing: the link word is stable for several cycles
        next_st.tx_stb = st.tog_s ^ st.tog_d;
        if (st.tog_s ^ st.tog_d) begin
            next_st.tx_pos = lk.word_pos;
            next_st.tx_neg = lk.word_neg & ~st.bypass;
            next_st.los    = st.bypass & ~lk.word_neg;
        end

        // receive line clock divider
        if (tick) begin
            next_st.div_cnt  = t1pli_pkg::DIV_RESET;
            next_st.line_clk = ~st.line_clk;
        end else begin
            next_st.div_cnt = st.div_cnt + 6'h01;
        end
        if (launch) begin
            next_st.rx_pos_q = rx_pos_data;
            next_st.rx_neg_q = rx_neg_data & ~st.bypass;
        end

        // line outputs
        // pin clock lags the internal one by a cycle so it moves on the same edge as the data pins
        next_st.clk_out = {4{st.line_clk}};
        next_st.clk_oe  = t1pli_drive(st.rx_en, st.hz_n);
        next_st.pos_out = st.rx_pos_q & ~st.sq;
        next_st.pos_oe  = t1pli_drive(st.rx_en | st.sq, st.hz_n);
        next_st.neg_out = st.rx_neg_q & ~st.sq;
        next_st.neg_oe  = t1pli_drive((st.rx_en & ~st.bypass) | st.sq, st.hz_n);

        // apb: one wait state, answer in the second access cycle
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;
        next_st.prdata  = 32'h00000000;
        case (st.bus)
            t1pli_pkg::T1PLI_BUS_IDLE: begin
                if (acc) begin
                    next_st.bus     = t1pli_pkg::T1PLI_BUS_ANSWER;
                    next_st.pready  = 1'b1;
                    next_st.pslverr = ~(addr_ctrl | (addr_stat & ~pwrite));
                    next_st.prdata  = 32'h00000000;
                    if (!pwrite && addr_ctrl) begin
                        next_st.prdata[t1pli_pkg::CTRL_RX_INV_BIT] = st.rx_inv;
                        next_st.prdata[t1pli_pkg::CTRL_TX_INV_BIT] = st.tx_inv;
                        next_st.prdata[t1pli_pkg::CTRL_BYPASS_LSB +: 4] = st.bypass;
                        next_st.prdata[t1pli_pkg::CTRL_RX_EN_LSB +: 4]  = st.rx_en;
                    end else if (!pwrite && addr_stat) begin
                        next_st.prdata[t1pli_pkg::STAT_TX_POS_LSB +: 4] = st.tx_pos;
                        next_st.prdata[t1pli_pkg::STAT_TX_NEG_LSB +: 4] = st.tx_neg;
                        next_st.prdata[t1pli_pkg::STAT_LOS_LSB +: 4]    = st.los;
                        next_st.prdata[t1pli_pkg::STAT_SQ_LSB +: 4]     = st.sq;
                        next_st.prdata[t1pli_pkg::STAT_HIZ_BIT]         = ~st.hz_n;
                    end
                end
            end
            t1pli_pkg::T1PLI_BUS_ANSWER: begin
                next_st.bus = t1pli_pkg::T1PLI_BUS_IDLE;
            end
            default: begin
                next_st.bus = t1pli_pkg::T1PLI_BUS_IDLE;
            end
        endcase
        if (wr_ok) begin
            next_st.rx_inv = pwdata[t1pli_pkg::CTRL_RX_INV_BIT];
            next_st.tx_inv = pwdata[t1pli_pkg::CTRL_TX_INV_BIT];
            next_st.bypass = pwdata[t1pli_pkg::CTRL_BYPASS_LSB +: 4];
            next_st.rx_en  = pwdata[t1pli_pkg::CTRL_RX_EN_LSB +: 4];
        end

        // control bits, status and outputs restart; software must rewrite control
        if (rst) begin
            next_st = '0;
            next_st.bus    = t1pli_pkg::T1PLI_BUS_IDLE;
            next_st.rx_inv = t1pli_pkg::RX_INV_RESET;
            next_st.tx_inv = t1pli_pkg::TX_INV_RESET;
            next_st.bypass = t1pli_pkg::BYPASS_RESET;
            next_st.rx_en  = t1pli_pkg::RX_EN_RESET;
            next_st.hz_m   = 1'b1;
            next_st.hz_n   = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        st <= next_st;
    end

    assign prdata            = st.prdata;
    assign pready            = st.pready;
    assign pslverr           = st.pslverr;
    assign rx_line_clock_out = st.clk_out;
    assign rx_line_clock_oe  = st.clk_oe;
    assign rx_pos_or_nrz_out = st.pos_out;
    assign rx_pos_or_nrz_oe  = st.pos_oe;
    assign rx_neg_rail_out   = st.neg_out;
    assign rx_neg_rail_oe    = st.neg_oe;
    assign tx_pos_sample     = st.tx_pos;
    assign tx_neg_sample     = st.tx_neg;
    assign tx_los_active     = st.los;
    assign tx_sample_strobe  = st.tx_stb;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_rise_edge;
        $rose(st.line_clk);
    endsequence

    sequence s_fall_edge;
        $fell(st.line_clk);
    endsequence

    a_rise_launch: assert property (($changed(st.rx_pos_q) && !$past(st.rx_inv)) |-> s_rise_edge)
        else $error("receive data moved away from the rising line edge");

    a_fall_launch: assert property (($changed(st.rx_pos_q) && $past(st.rx_inv)) |-> s_fall_edge)
        else $error("receive data moved away from the falling line edge");

    a_clock_half: assert property ($changed(st.line_clk) |-> $past(st.div_cnt) == t1pli_pkg::RX_HALF_LAST)
        else $error("line clock half period wrong");

    a_disable_float: assert property ((st.rx_en == 4'h0 && st.sq == 4'h0)[*2] |=> (st.clk_oe | st.pos_oe) == 4'h0)
        else $error("disabled port still driving");

    a_neg_bypass: assert property (((st.bypass & ~st.sq) != 4'h0)
                                   |=> (st.neg_oe & $past(st.bypass & ~st.sq)) == 4'h0)
        else $error("negative rail driven in bypass");

    a_squelch_zero: assert property ((st.sq != 4'h0 && st.hz_n)
                                     |=> ((st.pos_out | st.neg_out) & $past(st.sq)) == 4'h0
                                         && (st.pos_oe & $past(st.sq)) == $past(st.sq))
        else $error("squelch did not force zero");

    a_global_float: assert property (!st.hz_n |=> (st.clk_oe | st.pos_oe | st.neg_oe) == 4'h0)
        else $error("outputs driven under global tristate");

    a_los_follow: assert property ((st.tog_s ^ st.tog_d) |=> st.los == ($past(st.bypass) & ~$past(lk.word_neg)))
        else $error("loss of signal not taken from shared input");

    a_apb_wait: assert property ((acc && st.bus == t1pli_pkg::T1PLI_BUS_IDLE) |=> st.pready ##1 !st.pready)
        else $error("apb answer not exactly one cycle late");

    a_reset_ctrl: assert property (disable iff (1'b0) $past(rst) |-> (st.rx_en == 4'h0 && st.bypass == 4'h0
                                                                      && st.clk_oe == 4'h0))
        else $error("control not cleared by reset");

    a_tx_edge_pick: assert property (@(posedge tx_line_clock_in) disable iff (lk.rst_s)
                                     ((!lk.inv_s && !lk.rst_s) |=> lk.word_pos == $past(fc.pos)))
        else $error("transmit data not from falling edge");

endmodule

`default_nettype wire

/* hdl/t1pli_pkg.sv */
package t1pli_pkg;

    // ------------------------------------------------------------------
    // port count and line timing
    // ------------------------------------------------------------------
    localparam int NUM_PORTS    = 4;
    localparam int SYS_CLK_HZ   = 100_000_000;
    localparam int LINE_RATE_HZ = 1_544_000;
    // longest half period of the line clock, rounded down to whole cycles
    localparam int RX_HALF_CYC  = SYS_CLK_HZ / (2 * LINE_RATE_HZ);
    localparam int DIV_W        = 6;
    localparam logic [DIV_W-1:0] RX_HALF_LAST = DIV_W'(RX_HALF_CYC - 1);
    localparam logic [DIV_W-1:0] DIV_RESET    = 6'h00;

    // least hardware reset width, rounded up to whole cycles
    localparam int SYS_CLK_PERIOD_NS = 10;
    localparam int RESET_MIN_NS      = 150;
    localparam int RESET_MIN_CYC     = (RESET_MIN_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] CTRL_ADDR   = 12'h000;
    localparam logic [11:0] STATUS_ADDR = 12'h004;

    // control register fields
    localparam int CTRL_RX_INV_BIT = 0;
    localparam int CTRL_TX_INV_BIT = 1;
    localparam int CTRL_BYPASS_LSB = 4;
    localparam int CTRL_RX_EN_LSB  = 8;

    // status register fields
    localparam int STAT_TX_POS_LSB = 0;
    localparam int STAT_TX_NEG_LSB = 4;
    localparam int STAT_LOS_LSB    = 8;
    localparam int STAT_SQ_LSB     = 12;
    localparam int STAT_HIZ_BIT    = 16;

    // reset values of the control fields
    localparam logic       RX_INV_RESET = 1'b0;
    localparam logic       TX_INV_RESET = 1'b0;
    localparam logic [3:0] BYPASS_RESET = 4'h0;
    localparam logic [3:0] RX_EN_RESET  = 4'h0;

    // state of the system-side sequencer for one register access
    typedef enum logic [1:0] {
        T1PLI_BUS_IDLE = 2'b00,
        T1PLI_BUS_ANSWER = 2'b01
    } t1pli_bus_state_t;

endpackage

/* sim/t1pli_liu_model.sv */
`timescale 1ns/1ps
`default_nettype none

module t1pli_liu_model (
    // bit patterns launched after each line clock edge
    input  wire logic [3:0] pos_rise,
    input  wire logic [3:0] pos_fall,
    input  wire logic [3:0] neg_rise,
    input  wire logic [3:0] neg_fall,
    // line side towards the device
    output var  logic       line_clk,
    output var  logic [3:0] pos_line,
    output var  logic [3:0] neg_line,
    output var  logic       ref_clk
);
    // ------------------------------------------------------------------
    // free-running line and reference clocks
    // ------------------------------------------------------------------
    initial begin
        line_clk = 1'b0;
        forever #62.5 line_clk = ~line_clk;
    end

    initial begin
        ref_clk = 1'b0;
        forever #10.2804 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------------
    // data
    // ------------------------------------------------------------------
    // shared input idles high so no loss is reported until a pattern says so
    initial begin
        pos_line = 4'h0;
        neg_line = 4'hF;
    end

    // bits move 1 ns after each edge, so either sampling edge sees a settled bit
    always @(posedge line_clk) begin
        pos_line <= #1 pos_rise;
        neg_line <= #1 neg_rise;
    end

    always @(negedge line_clk) begin
        pos_line <= #1 pos_fall;
        neg_line <= #1 neg_fall;
    end
endmodule

`default_nettype wire

/* sim/test_t1pli_port_line.sv */
`timescale 1ns/1ps
`default_nettype none

module test_t1pli_port_line;
    typedef struct packed {
        logic [11:0] ctrl;
        logic [3:0]  sq;
        logic        hsel;
        logic [3:0]  c_oe;
        logic [3:0]  p_oe;
        logic [3:0]  n_oe;
    } t1pli_row_t;

    logic        clk_sys;
    logic        rst;
    logic        psel, penable, pwrite;
    logic [31:0] paddr, pwdata, prdata;
    logic        pready, pslverr;
    logic [3:0]  rx_pos_data, rx_neg_data, rx_squelch_in;
    logic [3:0]  rx_line_clock_out, rx_line_clock_oe, rx_pos_or_nrz_out, rx_pos_or_nrz_oe;
    logic [3:0]  rx_neg_rail_out, rx_neg_rail_oe, tx_pos_or_nrz_in, tx_neg_rail_or_los_in;
    logic [3:0]  tx_pos_sample, tx_neg_sample, tx_los_active, raw, byp;
    logic        tx_line_clock_in, tx_sample_strobe, global_tristate_select, desync_reference_clock;
    logic [31:0] r;
    logic        e, inv;
    int          miscompares, check_count, cycles;
    t1pli_row_t  rows [7];

    t1pli_port_line t1pli_port_line_i (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_pos_data(rx_pos_data), .rx_neg_data(rx_neg_data),
        .rx_line_clock_out(rx_line_clock_out), .rx_line_clock_oe(rx_line_clock_oe),
        .rx_pos_or_nrz_out(rx_pos_or_nrz_out), .rx_pos_or_nrz_oe(rx_pos_or_nrz_oe),
        .rx_neg_rail_out(rx_neg_rail_out), .rx_neg_rail_oe(rx_neg_rail_oe), .rx_squelch_in(rx_squelch_in),
        .tx_line_clock_in(tx_line_clock_in), .tx_pos_or_nrz_in(tx_pos_or_nrz_in),
        .tx_neg_rail_or_los_in(tx_neg_rail_or_los_in), .tx_pos_sample(tx_pos_sample),
        .tx_neg_sample(tx_neg_sample), .tx_los_active(tx_los_active), .tx_sample_strobe(tx_sample_strobe),
        .global_tristate_select(global_tristate_select), .desync_reference_clock(desync_reference_clock));

    t1pli_liu_model t1pli_liu_model_i (.pos_rise(4'h3), .pos_fall(4'hC), .neg_rise(4'h5), .neg_fall(4'hA),
        .line_clk(tx_line_clock_in), .pos_line(tx_pos_or_nrz_in), .neg_line(tx_neg_rail_or_los_in),
        .ref_clk(desync_reference_clock));

    // ------------------------------------------------------------------
    // clock, timeout and helpers
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // whole run needs about 1400 cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // request held until pready is sampled high at a rising edge; a hang is left to the timeout
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_line(input logic v);
        do begin
            @(negedge clk_sys);
        end while (rx_line_clock_out[0] !== v);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rows[0] = {12'h000, 4'h0, 1'b1, 4'h0, 4'h0, 4'h0};
        rows[1] = {12'hF03, 4'h0, 1'b1, 4'hF, 4'hF, 4'hF};
        rows[2] = {12'hFF0, 4'h0, 1'b1, 4'hF, 4'hF, 4'h0};
        rows[3] = {12'h3A0, 4'h0, 1'b1, 4'h3, 4'h3, 4'h1};
        rows[4] = {12'h000, 4'h6, 1'b1, 4'h0, 4'h6, 4'h6};
        rows[5] = {12'hF00, 4'h9, 1'b1, 4'hF, 4'hF, 4'hF};
        rows[6] = {12'hF00, 4'h0, 1'b0, 4'h0, 4'h0, 4'h0};
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {miscompares, check_count, cycles} = '0;
        rst = 1'b1;
        rx_pos_data = 4'hF;
        rx_neg_data = 4'hF;
        rx_squelch_in = 4'h0;
        global_tristate_select = 1'b1;
        // reset must last at least 150 ns; here it is held for 145 ns, across 15 rising clock edges
        repeat (14) @(posedge clk_sys);
        @(negedge clk_sys);
        check("oe_in_reset", rx_pos_or_nrz_oe, 32'h0);
        check("clk_oe_in_reset", rx_line_clock_oe, 32'h0);
        check("pready_in_reset", pready, 32'h0);
        @(posedge clk_sys);
        rst <= 1'b0;
        apb(1'b0, t1pli_pkg::CTRL_ADDR, 32'h0);
        check("ctrl_reset", r, 32'h0);
        apb(1'b1, t1pli_pkg::CTRL_ADDR, 32'h000005A3);
        apb(1'b0, t1pli_pkg::CTRL_ADDR, 32'h0);
        check("ctrl_back", r, 32'h000005A3);
        check("ctrl_err", e, 1'b0);
        apb(1'b1, t1pli_pkg::STATUS_ADDR, 32'hFFFFFFFF);
        check("status_wr_err", e, 1'b1);
        apb(1'b0, 32'h00000008, 32'h0);
        check("unmapped_err", e, 1'b1);
        check("unmapped_data", r, 32'h0);
        foreach (rows[i]) begin
            apb(1'b1, t1pli_pkg::CTRL_ADDR, {20'h0, rows[i].ctrl});
            rx_squelch_in <= rows[i].sq;
            global_tristate_select <= rows[i].hsel;
            repeat (80) @(posedge clk_sys);
            @(negedge clk_sys);
            check("clk_oe", rx_line_clock_oe, rows[i].c_oe);
            check("pos_oe", rx_pos_or_nrz_oe, rows[i].p_oe);
            check("neg_oe", rx_neg_rail_oe, rows[i].n_oe);
            check("pos_out", rx_pos_or_nrz_out & rx_pos_or_nrz_oe, ~rows[i].sq & rows[i].p_oe);
            check("neg_out", rx_neg_rail_out & rx_neg_rail_oe, ~rows[i].sq & rows[i].n_oe);
        end
        rx_squelch_in <= 4'h0;
        global_tristate_select <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            inv = k[0];
            apb(1'b1, t1pli_pkg::CTRL_ADDR, {31'h00000080, inv});
            rx_pos_data <= 4'h0;
            repeat (80) @(posedge clk_sys);
            // start from the first cycle of a high phase, well clear of the next fall
            wait_line(1'b0);
            wait_line(1'b1);
            @(posedge clk_sys);
            rx_pos_data <= 4'hF;
            wait_line(1'b0);
            check("launch_fall", rx_pos_or_nrz_out[0], inv);
            wait_line(1'b1);
            check("launch_rise", rx_pos_or_nrz_out[0], 1'b1);
        end
        for (int k = 0; k < 4; k++) begin
            inv = k[0];
            byp = k[1] ? 4'hF : 4'h0;
            raw = inv ? 4'hA : 4'h5;
            apb(1'b1, t1pli_pkg::CTRL_ADDR, {24'h0, byp, 2'b00, inv, 1'b0});
            repeat (60) @(posedge clk_sys);
            do begin
                @(negedge clk_sys);
            end while (tx_sample_strobe !== 1'b1);
            check("tx_pos", tx_pos_sample, inv ? 4'hC : 4'h3);
            check("tx_neg", tx_neg_sample, raw & ~byp);
            check("tx_los", tx_los_active, byp & ~raw);
            apb(1'b0, t1pli_pkg::STATUS_ADDR, 32'h0);
            check("status", r, {16'h0000, 4'h0, byp & ~raw, raw & ~byp, inv ? 4'hC : 4'h3});
            check("status_err", e, 1'b0);
        end
        // second reset in mid-run must clear the control bits again
        apb(1'b1, t1pli_pkg::CTRL_ADDR, 32'h00000F00);
        rst <= 1'b1;
        repeat (15) @(posedge clk_sys);
        @(negedge clk_sys);
        check("oe_mid_reset", rx_line_clock_oe, 32'h0);
        @(posedge clk_sys);
        rst <= 1'b0;
        apb(1'b0, t1pli_pkg::CTRL_ADDR, 32'h0);
        check("ctrl_mid_reset", r, 32'h0);
        conclude();
    end
endmodule

`default_nettype wire
